// [srp_device.sv]
// Device end of the serial register port with its register bank.
// Assumes the host keeps the serial clock at or below the rate limit.
//
// Functional notes
// - Three-wire or four-wire data wiring supported.
// - Four-wire: receive on data-in, reply on out.
// - Host drives clock and active-low select.
// - Shared bus systems use three-wire wiring only.
// - Select low, instruction, one to four bytes.
// - Direction bit: zero writes, one reads.
// - Two count bits give one to four bytes.
// - Start address, then descending per byte.
// - Serial clock at most fifteen megahertz.
// - Registers reset to their listed default values.
// - Frequency word bytes ascend from address three.
// - All settings programmable through this port.
// - Common bit seven chooses three-wire wiring.
// - Common bit six resets all other registers.
//
// Strobed register access was decided locally.
`default_nettype none
module srp_device (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Serial link
   srp_if.dev               link,
   // Configuration outputs
   output logic      [7:0]  common_control,
   output logic      [7:0]  transmit_path_config,
   output logic      [7:0]  pll_config,
   output logic      [31:0] oscillator_frequency_word,
   output logic             three_wire_select
);
   import srp_pkg::*;

   logic [2:0]     pins_s;
   logic           sclk_s;
   logic           sel_s;
   logic           din_s;
   logic           sclk_d_ff;
   logic           rise;
   logic           fall;
   srp_dev_state_e state_ff;
   logic [2:0]     bit_cnt_ff;
   logic [1:0]     byte_cnt_ff;
   logic [7:0]     rx_sh_ff;
   logic           rw_ff;
   logic [1:0]     nbytes_ff;
   logic [4:0]     addr_ff;
   logic [7:0]     tx_sh_ff;
   logic [7:0]     regs_ff [NUM_REGS];
   logic           byte_end;
   logic [4:0]     ins_addr;
   logic [7:0]     rx_byte;
   logic           wr_en;
   logic           bit_ff;
   logic           sdio_oe_ff;
   logic           sout_oe_ff;

   // Pins cross into clk before anything looks at them
   srp_sync u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    ({link.sclk, link.serial_select_low, link.sdio}),
      .q    (pins_s)
   );

   assign sclk_s = pins_s[2];
   assign sel_s  = pins_s[1];
   assign din_s  = pins_s[0];

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sclk_d_ff <= 1'b0;
      end else begin
         sclk_d_ff <= sclk_s;
      end
   end

   // Sample on rising, drive on falling serial clock
   assign rise = sclk_s & ~sclk_d_ff;
   assign fall = ~sclk_s & sclk_d_ff;

   assign byte_end = rise && (bit_cnt_ff == 3'h7);
   assign ins_addr = {rx_sh_ff[3:0], din_s};
   assign rx_byte  = {rx_sh_ff[6:0], din_s};

   function automatic logic [7:0] reg_read(input logic [4:0] a);
      if (a < NUM_REGS) begin
         return regs_ff[a[2:0]];
      end
      return 8'h00;
   endfunction

   // Transaction sequencing; select high always aborts
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= SRP_IDLE;
      end else if (sel_s) begin
         state_ff <= SRP_IDLE;
      end else begin
         unique case (state_ff)
            SRP_IDLE: begin
               state_ff <= SRP_INSTR;
            end
            SRP_INSTR: begin
               if (byte_end) begin
                  state_ff <= SRP_DATA;
               end
            end
            SRP_DATA: begin
               if (byte_end && (byte_cnt_ff == nbytes_ff)) begin
                  state_ff <= SRP_DONE;
               end
            end
            SRP_DONE: begin
               state_ff <= SRP_DONE;
            end
         endcase
      end
   end

   // Bit and byte counting
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_ff  <= 3'h0;
         byte_cnt_ff <= 2'h0;
      end else if (sel_s || (state_ff == SRP_IDLE)) begin
         bit_cnt_ff  <= 3'h0;
         byte_cnt_ff <= 2'h0;
      end else if (rise) begin
         bit_cnt_ff <= bit_cnt_ff + 3'h1;
         if (byte_end && (state_ff == SRP_DATA)) begin
            byte_cnt_ff <= byte_cnt_ff + 2'h1;
         end
      end
   end

   // Receive shifter, MSB first
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rx_sh_ff <= 8'h00;
      end else if (rise) begin
         rx_sh_ff <= rx_byte;
      end
   end

   // Instruction decode and address walk
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rw_ff     <= 1'b0;
         nbytes_ff <= 2'h0;
         addr_ff   <= 5'h00;
      end else if (byte_end && (state_ff == SRP_INSTR)) begin
         rw_ff     <= rx_sh_ff[6];
         nbytes_ff <= rx_sh_ff[5:4];
         addr_ff   <= ins_addr;
      end else if (byte_end && (state_ff == SRP_DATA)) begin
         addr_ff <= addr_ff - 5'h01;
      end
   end

   // Read shifter is reloaded at every byte boundary
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_sh_ff <= 8'h00;
      end else if (byte_end && (state_ff == SRP_INSTR)) begin
         tx_sh_ff <= reg_read(ins_addr);
      end else if (byte_end && (state_ff == SRP_DATA)) begin
         tx_sh_ff <= reg_read(addr_ff - 5'h01);
      end else if (fall && rw_ff) begin
         tx_sh_ff <= {tx_sh_ff[6:0], 1'b0};
      end
   end

   assign wr_en = byte_end && (state_ff == SRP_DATA) && !rw_ff;

   // Register bank; the port is the only configuration path
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_ff[i] <= srp_reg_default(3'(i));
         end
      end else if (wr_en) begin
         if (addr_ff == ADDR_COMMON) begin
            // Reset bit is a command and does not stick
            regs_ff[0] <= rx_byte & ~(8'h01 << BIT_SOFT_RST);
            if (rx_byte[BIT_SOFT_RST]) begin
               for (int i = 1; i < NUM_REGS; i++) begin
                  regs_ff[i] <= srp_reg_default(3'(i));
               end
            end
         end else if (addr_ff < NUM_REGS) begin
            regs_ff[addr_ff[2:0]] <= rx_byte;
         end
      end
   end

   // Read drive; pin choice follows the wiring bit
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bit_ff     <= 1'b0;
         sdio_oe_ff <= 1'b0;
         sout_oe_ff <= 1'b0;
      end else if (sel_s || !rw_ff ||
                   (state_ff == SRP_IDLE) || (state_ff == SRP_INSTR)) begin
         sdio_oe_ff <= 1'b0;
         sout_oe_ff <= 1'b0;
      end else if (fall) begin
         bit_ff     <= tx_sh_ff[7];
         sdio_oe_ff <= regs_ff[0][BIT_THREE_WIRE];
         sout_oe_ff <= ~regs_ff[0][BIT_THREE_WIRE];
      end
   end

   // A select that returns mid-byte leaves the bank untouched
   assign link.sdio_dev_o       = bit_ff;
   assign link.sdio_dev_oe      = sdio_oe_ff;
   assign link.serial_out_data_o = bit_ff;
   assign link.serial_out_oe    = sout_oe_ff;

   assign common_control       = regs_ff[ADDR_COMMON[2:0]];
   assign transmit_path_config = regs_ff[ADDR_TRANSMIT_PATH_CONFIG[2:0]];
   assign pll_config           = regs_ff[ADDR_PLL[2:0]];
   assign three_wire_select    = regs_ff[0][BIT_THREE_WIRE];
   // Low byte at address three, upward from there
   assign oscillator_frequency_word = {
      regs_ff[ADDR_FREQ3[2:0]], regs_ff[ADDR_FREQ2[2:0]],
      regs_ff[ADDR_FREQ1[2:0]], regs_ff[ADDR_FREQ0[2:0]]
   };
endmodule // srp_device
`default_nettype wire

// [srp_pkg.sv]
// Constants, types and helpers shared by both ends of the serial port.
// Assumes a single 100 MHz system clock on both ends.
`default_nettype none
package srp_pkg;
   // Timing
   localparam int CLK_FREQ_KHZ  = 100000;
   localparam int SCLK_MAX_KHZ  = 15000;
   localparam int SCLK_HALF_CYC =
      (CLK_FREQ_KHZ + 2 * SCLK_MAX_KHZ - 1) / (2 * SCLK_MAX_KHZ);
   localparam logic [2:0] SCLK_HALF_M1 = 3'(SCLK_HALF_CYC - 1);
   // Device register map
   localparam logic [4:0] ADDR_COMMON   = 5'h00;
   localparam logic [4:0] ADDR_TRANSMIT_PATH_CONFIG    = 5'h01;
   localparam logic [4:0] ADDR_PLL      = 5'h02;
   localparam logic [4:0] ADDR_FREQ0    = 5'h03;
   localparam logic [4:0] ADDR_FREQ1    = 5'h04;
   localparam logic [4:0] ADDR_FREQ2    = 5'h05;
   localparam logic [4:0] ADDR_FREQ3    = 5'h06;
   localparam logic [4:0] NUM_REGS      = 5'h07;
   localparam logic [7:0] RST_COMMON    = 8'h80;
   localparam logic [7:0] RST_TRANSMIT_PATH_CONFIG     = 8'h87;
   localparam logic [7:0] RST_PLL       = 8'h10;
   localparam logic [7:0] RST_FREQ      = 8'h66;
   localparam logic [7:0] RST_FREQ3     = 8'h26;
   localparam int BIT_THREE_WIRE = 7;
   localparam int BIT_SOFT_RST   = 6;
   // Instruction byte
   localparam int INS_RW = 7;
   // Controller register map
   localparam logic [7:0] HREG_CMD  = 8'h00;
   localparam logic [7:0] HREG_TX   = 8'h04;
   localparam logic [7:0] HREG_RX   = 8'h08;
   localparam logic [7:0] HREG_STAT = 8'h0C;
   localparam int CMD_START  = 0;
   localparam int CMD_RW     = 1;
   localparam int CMD_CNT_LO = 2;
   localparam int CMD_ADDR_LO = 4;
   localparam int CMD_3W     = 9;
   localparam int STAT_BUSY  = 0;
   localparam int STAT_DONE  = 1;

   typedef enum logic [1:0] {
      SRP_IDLE  = 2'b00,
      SRP_INSTR = 2'b01,
      SRP_DATA  = 2'b11,
      SRP_DONE  = 2'b10
   } srp_dev_state_e;

   typedef enum logic [1:0] {
      SRP_H_IDLE  = 2'b00,
      SRP_H_SETUP = 2'b01,
      SRP_H_SHIFT = 2'b11,
      SRP_H_HOLD  = 2'b10
   } srp_host_state_e;

   function automatic logic [7:0] srp_reg_default(input logic [2:0] idx);
      unique case (idx)
         3'h0:    return RST_COMMON;
         3'h1:    return RST_TRANSMIT_PATH_CONFIG;
         3'h2:    return RST_PLL;
         3'h6:    return RST_FREQ3;
         default: return RST_FREQ;
      endcase
   endfunction
endpackage
`default_nettype wire

// [srp_if.sv]
// Serial link between controller and device.
// Resolves the shared data pin; an undriven line reads high.
`default_nettype none
interface srp_if;
   logic sclk;
   logic serial_select_low;
   logic sdio_host_o;
   logic sdio_host_oe;
   logic sdio_dev_o;
   logic sdio_dev_oe;
   logic serial_out_data_o;
   logic serial_out_oe;
   logic sdio;
   logic serial_out_data;

   assign sdio = sdio_host_oe ? sdio_host_o :
                 (sdio_dev_oe ? sdio_dev_o : 1'b1);
   assign serial_out_data = serial_out_oe ? serial_out_data_o : 1'b1;

   modport dev (
      input  sclk, serial_select_low, sdio,
      output sdio_dev_o, sdio_dev_oe, serial_out_data_o, serial_out_oe
   );
   modport host (
      output sclk, serial_select_low, sdio_host_o, sdio_host_oe,
      input  sdio, serial_out_data
   );
endinterface
`default_nettype wire

// [srp_sync.sv]
// Two-stage synchroniser for the three link pins the device samples.
// Assumes the pins are asynchronous to clk.
`default_nettype none
module srp_sync (
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       rstn,
   // Pins
   input  wire logic [2:0] d,
   output logic      [2:0] q
);
   logic [2:0] meta_ff;

   // Clock rests low, select and data high: no false edge after reset
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         meta_ff <= 3'h3;
         q       <= 3'h3;
      end else begin
         meta_ff <= d;
         q       <= meta_ff;
      end
   end
endmodule // srp_sync
`default_nettype wire

// [srp_host.sv]
// Controller end: issues one serial transaction per software command.
// Assumes software matches the wiring mode to the device's setting.
`default_nettype none
module srp_host (
   // Clock and reset
   input  wire logic        clk,
   input  wire logic        rstn,
   // Software register port
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   // Serial link
   srp_if.host              link
);
   import srp_pkg::*;

   srp_host_state_e state_ff;
   logic [2:0]      div_ff;
   logic            sclk_ff;
   logic            sel_n_ff;
   logic            oe_ff;
   logic [39:0]     sh_ff;
   logic [5:0]      bit_ff;
   logic            rw_ff;
   logic [1:0]      cnt_ff;
   logic            three_ff;
   logic [31:0]     tx_ff;
   logic [31:0]     rx_ff;
   logic            done_ff;
   logic [31:0]     rdata_ff;
   logic            busy;
   logic            start;
   logic            last_edge;
   logic            fall_edge;
   logic [5:0]      last_bit;
   logic            din;
   logic [1:0]      w_cnt;
   logic [4:0]      w_shift;

   // Idle counter also spaces frames so the device sees select high
   assign busy      = (state_ff != SRP_H_IDLE) || (div_ff != SCLK_HALF_M1);
   assign start     = reg_wr && (reg_addr == HREG_CMD) &&
                      reg_wdata[CMD_START] && !busy;
   assign last_edge = (div_ff == SCLK_HALF_M1);
   assign fall_edge = (state_ff == SRP_H_SHIFT) && last_edge && sclk_ff;
   assign last_bit  = 6'({cnt_ff, 3'h0}) + 6'h0F;
   assign din       = three_ff ? link.sdio : link.serial_out_data;
   assign w_cnt     = reg_wdata[CMD_CNT_LO +: 2];
   assign w_shift   = {~w_cnt, 3'h0};

   // Frame sequencing and clock divider
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_ff <= SRP_H_IDLE;
         div_ff   <= SCLK_HALF_M1;
         sclk_ff  <= 1'b0;
         sel_n_ff <= 1'b1;
         bit_ff   <= 6'h00;
         sh_ff    <= 40'h0;
      end else begin
         unique case (state_ff)
            SRP_H_IDLE: begin
               if (start) begin
                  state_ff <= SRP_H_SETUP;
                  div_ff   <= 3'h0;
                  sel_n_ff <= 1'b0;
                  bit_ff   <= 6'h00;
                  sh_ff    <= {reg_wdata[CMD_RW], w_cnt,
                               reg_wdata[CMD_ADDR_LO +: 5],
                               tx_ff << w_shift};
               end else if (!last_edge) begin
                  div_ff <= div_ff + 3'h1;
               end
            end
            SRP_H_SETUP: begin
               div_ff <= last_edge ? 3'h0 : div_ff + 3'h1;
               if (last_edge) begin
                  state_ff <= SRP_H_SHIFT;
               end
            end
            SRP_H_SHIFT: begin
               div_ff <= last_edge ? 3'h0 : div_ff + 3'h1;
               if (last_edge) begin
                  sclk_ff <= ~sclk_ff;
               end
               if (fall_edge) begin
                  if (bit_ff == last_bit) begin
                     state_ff <= SRP_H_HOLD;
                  end else begin
                     bit_ff <= bit_ff + 6'h01;
                     sh_ff  <= {sh_ff[38:0], 1'b0};
                  end
               end
            end
            SRP_H_HOLD: begin
               div_ff <= last_edge ? 3'h0 : div_ff + 3'h1;
               if (last_edge) begin
                  state_ff <= SRP_H_IDLE;
                  sel_n_ff <= 1'b1;
               end
            end
         endcase
      end
   end

   // Data pin drive; handed to the device after a three-wire read instruction
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oe_ff <= 1'b0;
      end else if (start) begin
         oe_ff <= 1'b1;
      end else if (fall_edge && (bit_ff == 6'h07) && rw_ff && three_ff) begin
         oe_ff <= 1'b0;
      end else if ((state_ff == SRP_H_HOLD) && last_edge) begin
         oe_ff <= 1'b0;
      end
   end

   // Command fields and read capture
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rw_ff    <= 1'b0;
         cnt_ff   <= 2'h0;
         three_ff <= 1'b1;
         rx_ff    <= 32'h0;
      end else if (start) begin
         rw_ff    <= reg_wdata[CMD_RW];
         cnt_ff   <= w_cnt;
         three_ff <= reg_wdata[CMD_3W];
         rx_ff    <= 32'h0;
      end else if (fall_edge && rw_ff && (bit_ff > 6'h07)) begin
         rx_ff <= {rx_ff[30:0], din};
      end
   end

   // Set wins over a clear in the same cycle
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         done_ff <= 1'b0;
      end else if ((state_ff == SRP_H_HOLD) && last_edge) begin
         done_ff <= 1'b1;
      end else if (reg_wr && (reg_addr == HREG_STAT) &&
                   reg_wdata[STAT_DONE]) begin
         done_ff <= 1'b0;
      end
   end

   // Software port
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         tx_ff    <= 32'h0;
         rdata_ff <= 32'h0;
      end else begin
         if (reg_wr && (reg_addr == HREG_TX)) begin
            tx_ff <= reg_wdata;
         end
         rdata_ff <= 32'h0;
         if (reg_rd) begin
            unique case (reg_addr)
               HREG_CMD:  rdata_ff <= 32'({three_ff, 5'h00, cnt_ff,
                                           rw_ff, 1'b0});
               HREG_TX:   rdata_ff <= tx_ff;
               HREG_RX:   rdata_ff <= rx_ff;
               HREG_STAT: rdata_ff <= 32'({done_ff, busy});
               default:   rdata_ff <= 32'h0;
            endcase
         end
      end
   end

   assign reg_rdata              = rdata_ff;
   assign link.sclk              = sclk_ff;
   assign link.serial_select_low = sel_n_ff;
   assign link.sdio_host_o       = sh_ff[39];
   assign link.sdio_host_oe      = oe_ff;
endmodule // srp_host
`default_nettype wire

// [srp_checker.sv]
// Link checker: timing and framing seen on the serial link.
// Assumes it watches the one interface that joins both design ends.
`default_nettype none
module srp_checker (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rstn,
   // Link
   input  wire logic sclk,
   input  wire logic serial_select_low,
   input  wire logic sdio_host_o,
   input  wire logic sdio_host_oe,
   input  wire logic sdio_dev_oe,
   input  wire logic serial_out_oe,
   input  wire logic sdio
);
   timeunit 1ns;
   timeprecision 1ps;

   logic       sclk_d_ff;
   logic [5:0] rises_ff;
   logic [7:0] ins_ff;
   logic       rise;
   logic       dev_drv;

   assign rise    = sclk && !sclk_d_ff;
   assign dev_drv = sdio_dev_oe || serial_out_oe;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) sclk_d_ff <= 1'b0;
      else sclk_d_ff <= sclk;
   end
   // Rises within the current frame
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) rises_ff <= 6'h00;
      else if (serial_select_low) rises_ff <= 6'h00;
      else if (rise) rises_ff <= rises_ff + 6'h01;
   end
   // Instruction byte as sampled on the wire
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) ins_ff <= 8'h00;
      else if (rise && !serial_select_low && rises_ff < 6'h08)
         ins_ff <= {ins_ff[6:0], sdio};
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   sclk_idle_a: assert property (serial_select_low |-> !sclk)
      else $error("serial clock active outside a frame");
   select_setup_a: assert property (
      $fell(serial_select_low) |-> !sclk [*4])
      else $error("serial clock rose too soon after select");
   sclk_high_a: assert property ($rose(sclk) |-> sclk [*4])
      else $error("serial clock high phase too short");
   sclk_low_a: assert property ($fell(sclk) |-> !sclk [*4])
      else $error("serial clock low phase too short");
   pin_clash_a: assert property (!(sdio_host_oe && sdio_dev_oe))
      else $error("both ends drive the shared data pin");
   one_output_a: assert property (!(sdio_dev_oe && serial_out_oe))
      else $error("device drives both data outputs");
   frame_len_a: assert property (
      $rose(serial_select_low) |-> rises_ff == {ins_ff[6:5] + 3'h2, 3'h0})
      else $error("frame length does not match byte count");
   read_only_a: assert property (
      dev_drv && !serial_select_low |-> ins_ff[7])
      else $error("device drives data during a write");
   drive_start_a: assert property (
      $rose(dev_drv) |->
         !serial_select_low && rises_ff inside {[6'h08:6'h0A]})
      else $error("device starts driving at the wrong bit");
   pin_release_a: assert property (serial_select_low [*8] |-> !dev_drv)
      else $error("device still drives after select rose");
   host_stable_a: assert property (
      sdio_host_oe && sclk && sclk_d_ff |-> $stable(sdio_host_o))
      else $error("host data changed while serial clock high");

   cover property ($rose(sdio_dev_oe));
   cover property ($rose(serial_out_oe));
   cover property ($rose(serial_select_low) && rises_ff == 6'h28);
endmodule // srp_checker
`default_nettype wire

// [tb.sv]
// Bench: controller and device joined by the serial link.
// Assumes software traffic enters through the controller port only.
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import srp_pkg::*;

   localparam logic [31:0] ALL = 32'hFFFF_FFFF;

   logic        clk;
   logic        rstn;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [7:0]  common_control;
   logic [7:0]  tx_cfg;
   logic [7:0]  pll_cfg;
   logic [31:0] osc_word;
   logic        three_w;
   logic [31:0] cfg;
   logic [7:0]  mdl [0:6];
   logic [63:0] exp_q [$];
   logic [63:0] note;
   logic [31:0] seed;
   logic [4:0]  a;
   logic [1:0]  c;
   logic        rd_d;
   logic        four_w;
   logic        saw_dev;
   int          mismatches;
   int          checks_done;

   srp_if link ();
   assign cfg = {common_control, tx_cfg, pll_cfg, 7'h00, three_w};

   srp_host srp_host_i (
      .clk       (clk),
      .rstn      (rstn),
      .reg_addr  (reg_addr),
      .reg_wdata (reg_wdata),
      .reg_wr    (reg_wr),
      .reg_rd    (reg_rd),
      .reg_rdata (reg_rdata),
      .link      (link)
   );
   srp_device srp_device_i (
      .clk                       (clk),
      .rstn                      (rstn),
      .link                      (link),
      .common_control            (common_control),
      .transmit_path_config      (tx_cfg),
      .pll_config                (pll_cfg),
      .oscillator_frequency_word (osc_word),
      .three_wire_select         (three_w)
   );
   srp_checker srp_checker_i (
      .clk               (clk),
      .rstn              (rstn),
      .sclk              (link.sclk),
      .serial_select_low (link.serial_select_low),
      .sdio_host_o       (link.sdio_host_o),
      .sdio_host_oe      (link.sdio_host_oe),
      .sdio_dev_oe       (link.sdio_dev_oe),
      .serial_out_oe     (link.serial_out_oe),
      .sdio              (link.sdio)
   );

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      checks_done++;
      if (seen !== want) begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, want);
      end
   endtask

   task automatic results();
      $display("mismatches %0d checks_done %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] adr, input logic [31:0] d);
      @(posedge clk);
      reg_addr  <= adr;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] adr, input logic [31:0] v,
                     input logic [31:0] m);
      @(posedge clk);
      exp_q.push_back({m, v});
      reg_addr <= adr;
      reg_rd   <= 1'b1;
      @(posedge clk);
      reg_rd   <= 1'b0;
   endtask

   task automatic dflt();
      mdl[1] = RST_TRANSMIT_PATH_CONFIG;
      mdl[2] = RST_PLL;
      for (int i = 3; i < 6; i++) mdl[i] = RST_FREQ;
      mdl[6] = RST_FREQ3;
   endtask

   task automatic chk_cfg();
      check(cfg, {mdl[0], mdl[1], mdl[2], 7'h00, mdl[0][7]});
      check(osc_word, {mdl[6], mdl[5], mdl[4], mdl[3]});
   endtask

   // One frame; the model follows each byte to its descending address
   task automatic xfer(input logic rw, input logic [1:0] cnt,
                       input logic [4:0] adr, input logic tw,
                       input logic [31:0] tx);
      logic [31:0] e;
      logic [31:0] m;
      logic [9:0]  cmd;
      int          i;
      e = 32'h0;
      m = ~(ALL << (8 * (int'(cnt) + 1)));
      for (i = 0; i <= int'(cnt); i++) begin
         if (rw) e[8 * (int'(cnt) - i) +: 8] = mdl[int'(adr) - i];
         else mdl[int'(adr) - i] = tx[8 * (int'(cnt) - i) +: 8];
      end
      if (!rw && adr == 5'h00 && mdl[0][6]) dflt();
      if (!rw && adr == 5'h00) mdl[0][6] = 1'b0;
      cmd = {tw, adr, cnt, rw, 1'b1};
      wr(HREG_TX, tx);
      wr(HREG_CMD, {22'h0, cmd});
      repeat (2) @(posedge clk);
      rd(HREG_STAT, 32'h1, ALL);
      // A second start while busy must be ignored
      wr(HREG_CMD, {22'h0, cmd ^ 10'h20E});
      for (i = 0; i < 1000 && link.serial_select_low !== 1'b1; i++)
         @(posedge clk);
      if (i >= 1000) mismatches++;
      repeat (4) @(posedge clk);
      if (rw) rd(HREG_RX, e, m);
      rd(HREG_STAT, 32'h2, ALL);
      wr(HREG_STAT, 32'h2);
      rd(HREG_STAT, 32'h0, ALL);
      rd(HREG_CMD, {22'h0, cmd & 10'h20E}, ALL);
   endtask

   // Read data appear one cycle after the strobe
   always @(posedge clk) begin
      if (rd_d) begin
         note = exp_q.pop_front();
         check(reg_rdata & note[63:32], note[31:0]);
      end
      rd_d = reg_rd;
      if (four_w && link.sdio_dev_oe === 1'b1) saw_dev = 1'b1;
   end

   initial begin
      repeat (40000) @(posedge clk);
      mismatches++;
      results();
   end

   initial begin
      rstn      = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 32'h0;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      rd_d      = 1'b0;
      four_w    = 1'b0;
      saw_dev   = 1'b0;
      seed      = 32'h3EC38150;
      mdl[0]    = RST_COMMON;
      dflt();
      repeat (12) @(posedge clk);
      rstn <= 1'b1;
      rd(8'h10, 32'h0, ALL);
      chk_cfg();
      xfer(1'b1, 2'h3, 5'h05, 1'b1, 32'h0);
      xfer(1'b1, 2'h1, 5'h01, 1'b1, 32'h0);
      for (int k = 0; k < 12; k++) begin
         seed = lfsr(seed);
         a = 5'(seed[31:29] % 6 + 1);
         c = (seed[28:27] < a) ? seed[28:27] : 2'(a - 5'h01);
         xfer(seed[26], c, a, 1'b1, lfsr(seed));
         chk_cfg();
      end
      xfer(1'b0, 2'h0, 5'h00, 1'b1, 32'hC5);
      xfer(1'b1, 2'h3, 5'h06, 1'b1, 32'h0);
      chk_cfg();
      xfer(1'b0, 2'h0, 5'h00, 1'b1, 32'h05);
      chk_cfg();
      four_w = 1'b1;
      xfer(1'b1, 2'h3, 5'h06, 1'b0, 32'h0);
      xfer(1'b0, 2'h1, 5'h04, 1'b0, seed);
      xfer(1'b1, 2'h2, 5'h04, 1'b0, 32'h0);
      four_w = 1'b0;
      check({31'h0, saw_dev}, 32'h0);
      xfer(1'b0, 2'h0, 5'h00, 1'b0, 32'h80);
      xfer(1'b1, 2'h3, 5'h03, 1'b1, 32'h0);
      chk_cfg();
      results();
   end
endmodule // tb
`default_nettype wire
